// >>> tmr_pkg.sv
// How it works
// - writing one resets the shared prescaler
// - prescaler reset bit self-clears after reset
// - writing zero to reset bit does nothing
// - prescaler reset bit always reads zero
// - one prescaler reset hits both timers
// - sixteen-bit registers reached as two bytes
// - one high-byte latch shared by all
// - low-byte write loads latch plus data
// - counter and capture low-byte reads copy high byte to latch
// - compare high bytes read directly, latch untouched
// - no clock source selected means no counting
// - compares checked always, match sets flag
// - bottom is counter value zero
// - maximum is counter value all ones
// - top from fixed values, compare a or capture
// - compare a as top stays double buffered
// - four flags in flag register, each maskable
// - edge captures counter, optional noise filter
// - cpu counter write beats clear and count
// - capture flag set with capture copy
// - capture register writable only in capture-top modes
package tmr_pkg;
  // i/o addresses of the byte registers (arbitrary map for this block)
  localparam logic [5:0] A_CTRL = 6'h30;
  localparam logic [5:0] A_CNT_L = 6'h2c;
  localparam logic [5:0] A_CNT_H = 6'h2d;
  localparam logic [5:0] A_CMPA_L = 6'h2a;
  localparam logic [5:0] A_CMPA_H = 6'h2b;
  localparam logic [5:0] A_CMPB_L = 6'h28;
  localparam logic [5:0] A_CMPB_H = 6'h29;
  localparam logic [5:0] A_CAP_L = 6'h26;
  localparam logic [5:0] A_CAP_H = 6'h27;
  localparam logic [5:0] A_CFG = 6'h2e;
  localparam logic [5:0] A_FLAG = 6'h38;
  localparam logic [5:0] A_MASK = 6'h39;
  // special function control field
  localparam int PSR_BIT = 0;
  // config register fields: clock select, top select, capture edge, filter
  localparam int CS_LSB = 0;
  localparam int TOP_LSB = 3;
  localparam int EDGE_BIT = 6;
  localparam int FILT_BIT = 7;
  // flag / mask bit positions
  localparam int F_OVF = 0;
  localparam int F_CMPA = 1;
  localparam int F_CMPB = 2;
  localparam int F_CAP = 3;
  // counter limits
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] MAXV = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  // noise filter length in samples
  localparam int FILT_LEN = 4;
  // prescaler width (divides up to 1024)
  localparam int PRE_W = 10;
  typedef enum logic [2:0] {
    TOP_MAX = 3'h0, TOP_S8 = 3'h1, TOP_S9 = 3'h3, TOP_S10 = 3'h2,
    TOP_CMPA = 3'h6, TOP_CAP = 3'h7
  } tmr_top_t;
endpackage

// >>> tmr_timer16.sv
`timescale 1ns/1ps
module tmr_timer16 (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // cpu i/o bus
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // capture sources, asynchronous
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic use_comparator,
  // timer outputs
  output logic [3:0] flags_masked,
  output logic [tmr_pkg::PRE_W-1:0] prescaler_state,
  output logic timer_clock_enable
);
  // cpu-visible registers and internal state
  logic [7:0] temp_q; // shared high-byte latch
  logic [15:0] counter_value_q;
  logic [15:0] compare_a_value_q; // buffered copy seen by cpu
  logic [15:0] compare_b_value_q;
  logic [15:0] cmpa_act_q; // active copy used by compare and top
  logic [15:0] cmpb_act_q;
  logic [15:0] capture_value_q;
  logic [7:0] cfg_q;
  logic [3:0] timer_flag_register_q;
  logic [3:0] timer_mask_register_q;
  logic psr_q; // one-cycle prescaler reset request
  logic [tmr_pkg::PRE_W-1:0] pre_q;
  logic tick_q;
  logic [7:0] rdata_q;
  logic [3:0] fmask_q;

  // decoded strobes
  logic wr_cnt_l, wr_cmpa_l, wr_cmpb_l, wr_cap_l, wr_hi;
  logic rd_lo;
  logic [15:0] top_val;
  logic at_top, tick_d, cap_evt;
  tmr_pkg::tmr_top_t top_sel;

  // decode one address against a strobe; used for every write strobe and the low-byte read strobe
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ref_a, input logic s);
    hit = s && (a == ref_a);
  endfunction

  assign top_sel = tmr_pkg::tmr_top_t'(cfg_q[tmr_pkg::TOP_LSB +: 3]);
  assign wr_cnt_l = hit(io_addr, tmr_pkg::A_CNT_L, io_wr);
  assign wr_cmpa_l = hit(io_addr, tmr_pkg::A_CMPA_L, io_wr);
  assign wr_cmpb_l = hit(io_addr, tmr_pkg::A_CMPB_L, io_wr);
  // capture register accepts writes only when it sets the top
  assign wr_cap_l = hit(io_addr, tmr_pkg::A_CAP_L, io_wr) && (top_sel == tmr_pkg::TOP_CAP);
  // any high-byte write lands in the shared latch
  assign wr_hi = hit(io_addr, tmr_pkg::A_CNT_H, io_wr) || hit(io_addr, tmr_pkg::A_CMPA_H, io_wr)
    || hit(io_addr, tmr_pkg::A_CMPB_H, io_wr) || hit(io_addr, tmr_pkg::A_CAP_H, io_wr);
  // compare low reads are excluded so the latch is left alone
  assign rd_lo = hit(io_addr, tmr_pkg::A_CNT_L, io_rd) || hit(io_addr, tmr_pkg::A_CAP_L, io_rd);

  // top selection: fixed values, compare a or capture
  always_comb begin
    case (top_sel)
      tmr_pkg::TOP_S8: top_val = tmr_pkg::TOP_8;
      tmr_pkg::TOP_S9: top_val = tmr_pkg::TOP_9;
      tmr_pkg::TOP_S10: top_val = tmr_pkg::TOP_10;
      tmr_pkg::TOP_CMPA: top_val = cmpa_act_q;
      tmr_pkg::TOP_CAP: top_val = capture_value_q;
      default: top_val = tmr_pkg::MAXV;
    endcase
  end
  assign at_top = (counter_value_q == top_val);

  // prescaler reset bit: pulse for one cycle, never stored readable
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      psr_q <= 1'b0;
    end else begin
      // writing zero leaves the pulse low
      psr_q <= hit(io_addr, tmr_pkg::A_CTRL, io_wr) && io_wdata[tmr_pkg::PSR_BIT];
    end
  end

  // free running shared prescaler, cleared by the reset pulse
  // limitation: the other timer shares this count, so a reset shifts its ticks too
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pre_q <= '0;
    end else if (psr_q) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // clock select: taps 1, 8, 64, 256, 1024; zero stops the timer
  always_comb begin
    case (cfg_q[tmr_pkg::CS_LSB +: 3])
      3'h1: tick_d = 1'b1;
      3'h2: tick_d = (pre_q[2:0] == 3'h7);
      3'h3: tick_d = (pre_q[5:0] == 6'h3f);
      3'h4: tick_d = (pre_q[7:0] == 8'hff);
      3'h5: tick_d = (pre_q == 10'h3ff);
      default: tick_d = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tick_q <= 1'b0;
    end else begin
      // no tick escapes from the prescaler while its reset pulse stands
      tick_q <= tick_d && !psr_q;
    end
  end

  // capture input: every asynchronous level gets its own two-stage sync,
  // the source mux sits after them so a select change never upsets a stage
  logic [1:0] cap_sync_q; // capture pin synchroniser
  logic [1:0] cmp_sync_q; // comparator output synchroniser
  logic [1:0] sel_sync_q; // source select synchroniser
  logic cap_src; // selected, synchronised capture level
  logic [tmr_pkg::FILT_LEN-1:0] filt_q;
  logic cap_lvl_q, cap_prev_q;
  assign cap_src = sel_sync_q[1] ? cmp_sync_q[1] : cap_sync_q[1];
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cap_sync_q <= '0;
      cmp_sync_q <= '0;
      sel_sync_q <= '0;
      filt_q <= '0;
      cap_lvl_q <= 1'b0;
      cap_prev_q <= 1'b0;
    end else begin
      cap_sync_q <= {cap_sync_q[0], capture_input_pin};
      cmp_sync_q <= {cmp_sync_q[0], comparator_out};
      sel_sync_q <= {sel_sync_q[0], use_comparator};
      filt_q <= {filt_q[tmr_pkg::FILT_LEN-2:0], cap_src};
      // filter only moves the level after a full run of equal samples
      if (!cfg_q[tmr_pkg::FILT_BIT]) begin
        cap_lvl_q <= cap_src;
      end else if (&filt_q) begin
        cap_lvl_q <= 1'b1;
      end else if (~|filt_q) begin
        cap_lvl_q <= 1'b0;
      end
      cap_prev_q <= cap_lvl_q;
    end
  end
  assign cap_evt = cfg_q[tmr_pkg::EDGE_BIT] ? (cap_lvl_q && !cap_prev_q)
                                            : (!cap_lvl_q && cap_prev_q);

  // counter: cpu write first, then clear at top, then count
  // a write while counting lands mid-sequence; stop the timer for a clean load
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      counter_value_q <= tmr_pkg::BOTTOM;
    end else if (wr_cnt_l) begin
      counter_value_q <= {temp_q, io_wdata};
    end else if (tick_q && at_top) begin
      counter_value_q <= tmr_pkg::BOTTOM;
    end else if (tick_q) begin
      counter_value_q <= counter_value_q + 16'h0001;
    end
  end

  // compare registers: cpu copy, moved to active copy at bottom
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      compare_a_value_q <= '0;
      compare_b_value_q <= '0;
      cmpa_act_q <= '0;
      cmpb_act_q <= '0;
    end else begin
      if (wr_cmpa_l) begin
        compare_a_value_q <= {temp_q, io_wdata};
      end
      if (wr_cmpb_l) begin
        compare_b_value_q <= {temp_q, io_wdata};
      end
      // double buffering: update only while the counter sits at bottom
      if (counter_value_q == tmr_pkg::BOTTOM) begin
        cmpa_act_q <= compare_a_value_q;
        cmpb_act_q <= compare_b_value_q;
      end
    end
  end

  // capture register: edge copies the counter unless capture is the top, else cpu write
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      capture_value_q <= '0;
    end else if (top_sel != tmr_pkg::TOP_CAP && cap_evt) begin
      capture_value_q <= counter_value_q;
    end else if (wr_cap_l) begin
      capture_value_q <= {temp_q, io_wdata};
    end
  end

  // shared high-byte latch
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      temp_q <= '0;
    end else if (wr_hi) begin
      temp_q <= io_wdata;
    end else if (rd_lo) begin
      // compare low reads never get here, so the latch keeps its byte
      if (io_addr == tmr_pkg::A_CNT_L) begin
        temp_q <= counter_value_q[15:8];
      end else begin
        temp_q <= capture_value_q[15:8];
      end
    end
  end

  // config and mask registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cfg_q <= '0;
      timer_mask_register_q <= '0;
    end else begin
      if (hit(io_addr, tmr_pkg::A_CFG, io_wr)) begin
        cfg_q <= io_wdata;
      end
      if (hit(io_addr, tmr_pkg::A_MASK, io_wr)) begin
        timer_mask_register_q <= io_wdata[3:0];
      end
    end
  end

  // flags: hardware set wins over a write-one clear in the same cycle
  // trade-off: a clear that lands on a match is lost, but no event is missed
  logic [3:0] fset;
  assign fset = {cap_evt && top_sel != tmr_pkg::TOP_CAP,
                 counter_value_q == cmpb_act_q,
                 counter_value_q == cmpa_act_q,
                 tick_q && at_top}; // overflow at wrap
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      timer_flag_register_q <= '0;
    end else begin
      timer_flag_register_q <= fset | (timer_flag_register_q &
        ~(hit(io_addr, tmr_pkg::A_FLAG, io_wr) ? io_wdata[3:0] : 4'h0));
    end
  end

  // read mux, registered; high bytes return the latch except compares
  // registered so read data leaves a flip-flop; it trails the strobe by a cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else begin
      case (io_addr)
        tmr_pkg::A_CTRL: rdata_q <= 8'h00;
        tmr_pkg::A_CNT_L: rdata_q <= counter_value_q[7:0];
        tmr_pkg::A_CNT_H: rdata_q <= temp_q;
        tmr_pkg::A_CMPA_L: rdata_q <= compare_a_value_q[7:0];
        tmr_pkg::A_CMPA_H: rdata_q <= compare_a_value_q[15:8];
        tmr_pkg::A_CMPB_L: rdata_q <= compare_b_value_q[7:0];
        tmr_pkg::A_CMPB_H: rdata_q <= compare_b_value_q[15:8];
        tmr_pkg::A_CAP_L: rdata_q <= capture_value_q[7:0];
        tmr_pkg::A_CAP_H: rdata_q <= temp_q;
        tmr_pkg::A_CFG: rdata_q <= cfg_q;
        tmr_pkg::A_FLAG: rdata_q <= {4'h0, timer_flag_register_q};
        tmr_pkg::A_MASK: rdata_q <= {4'h0, timer_mask_register_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fmask_q <= '0;
    end else begin
      fmask_q <= timer_flag_register_q & timer_mask_register_q;
    end
  end

  assign io_rdata = rdata_q;
  assign flags_masked = fmask_q;
  assign prescaler_state = pre_q;
  assign timer_clock_enable = tick_q;

  // assertions
  // each one checks design state, several of them against the bus address, strobes and data
  a_psr_clears_pre: assert property (@(posedge core_clk) disable iff (!reset_n)
    psr_q |=> pre_q == '0) else $error("prescaler not reset");
  a_psr_one_cycle: assert property (@(posedge core_clk) disable iff (!reset_n)
    psr_q |=> !psr_q || $past(io_wr)) else $error("reset bit stuck");
  a_psr_zero_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    (io_wr && io_addr == tmr_pkg::A_CTRL && !io_wdata[0]) |=> !psr_q)
    else $error("zero write reset prescaler");
  a_psr_reads_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    (io_rd && io_addr == tmr_pkg::A_CTRL) |=> io_rdata == 8'h00)
    else $error("reset bit read nonzero");
  a_lo_write_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_cnt_l |=> counter_value_q == {$past(temp_q), $past(io_wdata)})
    else $error("counter not loaded");
  a_lo_read_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
    (io_rd && io_addr == tmr_pkg::A_CNT_L && !wr_hi) |=> temp_q == $past(counter_value_q[15:8]))
    else $error("latch not filled");
  a_cmp_read_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
    (io_rd && !io_wr && io_addr == tmr_pkg::A_CMPA_L) |=> $stable(temp_q))
    else $error("compare read moved latch");
  a_stop_no_count: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cfg_q[2:0] == 3'h0 && !wr_cnt_l ##1 !wr_cnt_l) |=> $stable(counter_value_q))
    else $error("counted without clock");
  a_cmp_flag_set: assert property (@(posedge core_clk) disable iff (!reset_n)
    (counter_value_q == cmpa_act_q) |=> timer_flag_register_q[1])
    else $error("compare flag missing");
  a_cap_flag_same: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cap_evt && top_sel != tmr_pkg::TOP_CAP) |=> timer_flag_register_q[3]
      && capture_value_q == $past(counter_value_q)) else $error("capture flag skew");

  // multi-step behaviours spelled out as named sequences, then single-step checks
  sequence s_psr_request;
    io_wr && io_addr == tmr_pkg::A_CTRL && io_wdata[tmr_pkg::PSR_BIT];
  endsequence
  sequence s_psr_done;
    psr_q ##1 (pre_q == '0);
  endsequence
  sequence s_cnt_low_read;
    io_rd && !io_wr && io_addr == tmr_pkg::A_CNT_L;
  endsequence
  sequence s_latch_high_read;
    io_rd && !io_wr && io_addr == tmr_pkg::A_CNT_H;
  endsequence
  a_psr_full_path: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_psr_request |=> s_psr_done)
    else $error("prescaler reset path broken");
  a_cnt_pair_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_cnt_low_read ##1 (!io_wr && !io_rd) ##1 s_latch_high_read
      |=> io_rdata == $past(counter_value_q[15:8], 3)) else $error("counter pair torn");
  a_cmpb_flag_set: assert property (@(posedge core_clk) disable iff (!reset_n)
    (counter_value_q == cmpb_act_q) |=> timer_flag_register_q[tmr_pkg::F_CMPB])
    else $error("compare b flag missing");
  a_top_wrap_bottom: assert property (@(posedge core_clk) disable iff (!reset_n)
    (tick_q && at_top && !wr_cnt_l) |=> counter_value_q == tmr_pkg::BOTTOM)
    else $error("counter missed wrap at top");
  a_stopped_no_tick: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cfg_q[tmr_pkg::CS_LSB +: 3] == 3'h0) |=> !tick_q)
    else $error("tick while stopped");
  a_cap_write_refused: assert property (@(posedge core_clk) disable iff (!reset_n)
    (io_wr && io_addr == tmr_pkg::A_CAP_L && top_sel != tmr_pkg::TOP_CAP && !cap_evt)
      |=> $stable(capture_value_q)) else $error("capture write not refused");
  a_mask_output: assert property (@(posedge core_clk) disable iff (!reset_n)
    1'b1 |=> flags_masked == ($past(timer_flag_register_q) & $past(timer_mask_register_q)))
    else $error("masked flags wrong");
endmodule

// >>> tmr_cpu_model.sv
`timescale 1ns/1ps
module tmr_cpu_model (
  // bus clock
  input wire logic core_clk,
  // byte bus toward the timer
  output logic [5:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  // idle bus at time zero
  initial begin
    io_addr = 6'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // one byte write; the strobe is seen at exactly one rising edge
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge core_clk);
    io_wr = 1'b0;
    // inverted data after release so a stale byte never looks valid
    io_wdata = ~d;
  endtask
  // one byte read; data is registered and settled one cycle later
  task automatic rd8(input logic [5:0] a, output logic [7:0] d);
    @(negedge core_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge core_clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask
  // high byte first, so the latch holds it when the low write commits
  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    wr8(a + 6'h01, d[15:8]);
    wr8(a, d[7:0]);
  endtask
  // low byte first, so the latch is loaded before the high read
  task automatic rd16(input logic [5:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(a + 6'h01, d[15:8]);
  endtask
  // single master with no interrupt code, so no pair is ever split
endmodule

// >>> timer16_byte_access_prescaler_reset_test.sv
`timescale 1ns/1ps
module timer16_byte_access_prescaler_reset_test;
  // clock, reset and capture sources
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cap_pin = 1'b0;
  logic cmp_out = 1'b0;
  logic use_cmp = 1'b0;
  // bus and outputs
  logic [5:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic [3:0] flags_masked;
  logic [tmr_pkg::PRE_W-1:0] pre_state;
  logic timer_clock_enable;
  // tallies and random source
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'heac3;
  // reference copies of the sixteen-bit registers, by low address
  int m_reg[int];
  always #4 core_clk = ~core_clk;
  tmr_cpu_model cpu (.core_clk(core_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata));
  tmr_timer16 uut (.core_clk(core_clk), .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .capture_input_pin(cap_pin),
    .comparator_out(cmp_out), .use_comparator(use_cmp), .flags_masked(flags_masked),
    .prescaler_state(pre_state), .timer_clock_enable(timer_clock_enable));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // wait on one masked flag, bounded
  task automatic wait_flag(input int b, input int lim, output int n);
    n = 0;
    while (flags_masked[b] !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  // count timer ticks over a span
  task automatic ticks(input int cyc, output int t);
    t = 0;
    repeat (cyc) begin
      @(negedge core_clk);
      if (timer_clock_enable === 1'b1) t++;
    end
  endtask
  // watchdog, far beyond the few thousand cycles the sequence needs
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
  initial begin
    logic [15:0] v;
    logic [7:0] b;
    logic [9:0] p;
    int n;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    chk("flags after reset", 16'h0000, {12'h000, flags_masked});
    // prescaler reset: one written, cleared within a cycle, reads zero
    repeat (30) @(negedge core_clk);
    cpu.wr8(tmr_pkg::A_CTRL, 8'h01);
    // the pulse stands one cycle, so the prescaler shows zero one cycle later
    @(negedge core_clk);
    chk("prescaler cleared", 16'h0000, {6'h00, pre_state});
    cpu.rd8(tmr_pkg::A_CTRL, b);
    chk("reset bit read", 16'h0000, {8'h00, b});
    repeat (20) @(negedge core_clk);
    p = pre_state;
    cpu.wr8(tmr_pkg::A_CTRL, 8'h00);
    chk("prescaler kept", {6'h00, p + 10'h002}, {6'h00, pre_state});
    // stopped timer: random counter and compare values round-trip
    for (int i = 0; i < 6; i++) begin
      int a;
      seed = lfsr(seed);
      a = (i % 3 == 0) ? tmr_pkg::A_CNT_L : (i % 3 == 1) ? tmr_pkg::A_CMPA_L : tmr_pkg::A_CMPB_L;
      m_reg[a] = seed[15:0];
      cpu.wr16(a[5:0], seed[15:0]);
      cpu.rd16(a[5:0], v);
      chk("register readback", m_reg[a][15:0], v);
    end
    // compare high read is direct and leaves the latch alone
    cpu.rd8(tmr_pkg::A_CNT_L, b);
    cpu.rd8(tmr_pkg::A_CMPA_H, b);
    chk("compare a high", {8'h00, m_reg[tmr_pkg::A_CMPA_L][15:8]}, {8'h00, b});
    cpu.rd8(tmr_pkg::A_CNT_H, b);
    chk("counter high", {8'h00, m_reg[tmr_pkg::A_CNT_L][15:8]}, {8'h00, b});
    // one latch: high byte of one register lands in another
    cpu.wr8(tmr_pkg::A_CMPA_H, 8'hc3);
    cpu.wr8(tmr_pkg::A_CMPB_L, 8'h3c);
    cpu.rd16(tmr_pkg::A_CMPB_L, v);
    chk("shared latch", 16'hc33c, v);
    // capture writes refused unless capture is the top
    cpu.wr16(tmr_pkg::A_CAP_L, 16'h1234);
    cpu.rd16(tmr_pkg::A_CAP_L, v);
    chk("capture refused", 16'h0000, v);
    cpu.wr8(tmr_pkg::A_CFG, 8'h38);
    cpu.wr16(tmr_pkg::A_CAP_L, 16'h1234);
    cpu.rd16(tmr_pkg::A_CAP_L, v);
    chk("capture written", 16'h1234, v);
    cpu.rd8(6'h3f, b);
    chk("unmapped read", 16'h0000, {8'h00, b});
    // overflow at the eight-bit top: 0x00f0 wraps after sixteen ticks
    cpu.wr8(tmr_pkg::A_CFG, 8'h00);
    cpu.wr16(tmr_pkg::A_CNT_L, 16'h00f0);
    cpu.wr8(tmr_pkg::A_MASK, 8'h01);
    cpu.wr8(tmr_pkg::A_CFG, 8'h09);
    wait_flag(0, 40, n);
    chk("overflow delay", 16'h0001, {15'h0000, n >= 12 && n <= 22});
    cpu.rd8(tmr_pkg::A_FLAG, b);
    chk("overflow flag", 16'h0001, {15'h0000, b[tmr_pkg::F_OVF]});
    // both compares match while counting, each seen through its mask
    cpu.wr16(tmr_pkg::A_CMPA_L, 16'h0040);
    cpu.wr16(tmr_pkg::A_CMPB_L, 16'h0080);
    cpu.wr8(tmr_pkg::A_MASK, 8'h06);
    cpu.wr8(tmr_pkg::A_FLAG, 8'h0f);
    // let the stale registered flags pass before waiting
    @(negedge core_clk);
    wait_flag(1, 700, n);
    wait_flag(2, 700, n);
    chk("compare flags", 16'h0006, {12'h000, flags_masked});
    cpu.wr8(tmr_pkg::A_MASK, 8'h00);
    repeat (2) @(negedge core_clk);
    chk("all masked", 16'h0000, {12'h000, flags_masked});
    // rising edge on the capture pin stamps a stopped counter
    cpu.wr8(tmr_pkg::A_CFG, 8'h40);
    cpu.wr16(tmr_pkg::A_CNT_L, 16'h5a5a);
    cpu.wr8(tmr_pkg::A_MASK, 8'h08);
    cpu.wr8(tmr_pkg::A_FLAG, 8'h0f);
    @(negedge core_clk);
    cap_pin = 1'b1;
    wait_flag(3, 20, n);
    chk("capture flag", 16'h0001, {15'h0000, n < 20});
    cpu.rd16(tmr_pkg::A_CAP_L, v);
    chk("capture value", 16'h5a5a, v);
    // comparator source, falling edge through the noise filter
    cmp_out = 1'b1;
    use_cmp = 1'b1;
    cpu.wr8(tmr_pkg::A_CFG, 8'h80);
    cpu.wr16(tmr_pkg::A_CNT_L, 16'h0321);
    cpu.wr8(tmr_pkg::A_FLAG, 8'h0f);
    @(negedge core_clk);
    cmp_out = 1'b0;
    wait_flag(3, 20, n);
    chk("filtered capture", 16'h0001, {15'h0000, n < 20});
    cpu.rd16(tmr_pkg::A_CAP_L, v);
    chk("capture value cmp", 16'h0321, v);
    // divide by eight gives eight ticks in 64 cycles; no source gives none
    cpu.wr8(tmr_pkg::A_CFG, 8'h02);
    ticks(64, n);
    chk("ticks div8", 16'h0008, n[15:0]);
    cpu.wr8(tmr_pkg::A_CFG, 8'h03);
    ticks(256, n);
    chk("ticks div64", 16'h0004, n[15:0]);
    cpu.wr8(tmr_pkg::A_CFG, 8'h04);
    ticks(512, n);
    chk("ticks div256", 16'h0002, n[15:0]);
    cpu.wr8(tmr_pkg::A_CFG, 8'h05);
    ticks(2048, n);
    chk("ticks div1024", 16'h0002, n[15:0]);
    cpu.wr8(tmr_pkg::A_CFG, 8'h00);
    ticks(64, n);
    chk("ticks stopped", 16'h0000, n[15:0]);
    // compare a as top: the running count never passes it
    cpu.wr16(tmr_pkg::A_CMPA_L, 16'h0010);
    cpu.wr16(tmr_pkg::A_CNT_L, 16'h0000);
    cpu.wr8(tmr_pkg::A_CFG, 8'h31);
    repeat (100) @(negedge core_clk);
    cpu.rd16(tmr_pkg::A_CNT_L, v);
    chk("compare a top", 16'h0001, {15'h0000, v <= 16'h0010});
    stop_test();
  end
endmodule
